// ---- design/sar_adc_pkg.sv ----
// package: register map, mode fields, timing constants and types of the converter control
package sar_adc_pkg;

    // register byte addresses
    localparam logic [15:0] MODE_ADDR      = 16'hff80;
    localparam logic [15:0] RESULT_ADDR    = 16'hff84;
    localparam logic [15:0] PIN_SEL_ADDR   = 16'hff88;
    localparam logic [15:0] EDGE_MODE_ADDR = 16'hff8c;
    localparam logic [15:0] STATUS_ADDR    = 16'hff90;

    // reset values
    localparam logic [7:0] MODE_RESET      = 8'h01;
    localparam logic [7:0] PIN_SEL_RESET   = 8'h00;
    localparam logic [7:0] EDGE_MODE_RESET = 8'h00;

    // mode register field positions
    localparam int RUN_BIT       = 7;
    localparam int EXT_START_BIT = 6;
    localparam int SPEED_HI_BIT  = 5;
    localparam int SPEED_LO_BIT  = 4;
    localparam int CHANNEL_MSB   = 3;
    localparam int CHANNEL_LSB   = 1;
    localparam int RANGE_BIT     = 0;

    // status register field positions
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_WAIT_BIT = 1;
    localparam int STAT_IDX_LSB  = 2;

    // trigger edge selection held in bits 1:0 of the edge mode register
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;

    // speed patterns {hi, lo, range}
    localparam logic [2:0] SPEED_P001 = 3'h1;
    localparam logic [2:0] SPEED_P011 = 3'h3;
    localparam logic [2:0] SPEED_P100 = 3'h4;
    localparam logic [2:0] SPEED_P101 = 3'h5;

    // conversion length in oscillator periods with the divider bit set
    localparam int CONV_PERIODS_P001 = 80;
    localparam int CONV_PERIODS_P011 = 40;
    localparam int CONV_PERIODS_P100 = 50;
    localparam int CONV_PERIODS_P101 = 100;
    // one conversion: two sampling slots and eight bit slots
    localparam int SLOTS_PER_CONV    = 10;
    localparam int SAMPLE_SLOTS      = 2;

    localparam int DATA_W = 8;

    typedef struct packed {
        logic       run;
        logic       ext_start;
        logic       speed_select_hi;
        logic       speed_select_lo;
        logic [2:0] channel;
        logic       speed_range_bit;
    } mode_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_TRIG,
        ST_SAMPLE,
        ST_CONVERT
    } conv_state_e;

endpackage

// ---- design/sar_adc_control.sv ----
// successive-approximation converter control with a classic wishbone register slave
// Functional notes
// - eight selectable analog channels, eight-bit result for the chosen channel.
// - successive approximation; result kept in readable eight-bit result register.
// - hardware start converts once per external trigger, then stops and requests interrupt.
// - software start converts back to back, interrupt request after every conversion.
// - approximation resolves MSB first; after LSB its value moves to the result.
// - result reloaded at each conversion end, read as a byte, undefined after reset; this design clears it to 00h.
// - mode register resets to 01h (stopped, software start); bit and byte writes.
// - mode bits: 7 run, 6 trigger select, 5:4 speed, 3:1 channel, 0 range.
// - channel field binary value selects analog input zero through seven.
// - speed bits set conversion length in oscillator periods; other patterns prohibited.
// - trigger select 0 means software start, 1 means external trigger start.
// - run bit 0 stops conversion activity, 1 starts or enables it.
// - trigger active edge comes from bits 1:0 of the edge mode register.
// - pins not chosen as analog stay ordinary digital port pins.
// - hardware start: run write mid-conversion aborts and waits for a new trigger.
// - software start: run write mid-conversion aborts and restarts with new settings.
// - write with run cleared mid-conversion halts at once, no completion.
`timescale 1ns/100ps
`default_nettype none

module sar_adc_control #(
    parameter int FX_DIV = 1
) (
    // clock and reset
    input  wire logic                           i_core_clk,
    input  wire logic                           i_nrst,
    // wishbone slave
    input  wire logic                           i_wb_cyc,
    input  wire logic                           i_wb_stb,
    input  wire logic                           i_wb_we,
    input  wire logic [15:0]                    i_wb_adr,
    input  wire logic [31:0]                    i_wb_dat,
    input  wire logic [3:0]                     i_wb_sel,
    output logic      [31:0]                    o_wb_dat,
    output logic                                o_wb_ack,
    // system inputs
    input  wire logic                           i_clock_divider_select,
    input  wire logic                           i_conversion_trigger_in,
    // analog front end
    input  wire logic                           i_comparator,
    output logic      [2:0]                     o_channel_sel,
    output logic                                o_sample,
    output logic      [sar_adc_pkg::DATA_W-1:0] o_tap_code,
    output logic      [7:0]                     o_analog_pin_select,
    // interrupt request
    output logic                                o_conversion_done_irq
);

    localparam int PRE_W = (FX_DIV > 1) ? $clog2(FX_DIV) : 1;

    // slot length in oscillator periods for the mode and divider bit
    function automatic logic [6:0] slot_len(input sar_adc_pkg::mode_s m, input logic div_sel);
        int periods;
        periods = sar_adc_pkg::CONV_PERIODS_P101;
        case ({m.speed_select_hi, m.speed_select_lo, m.speed_range_bit})
            sar_adc_pkg::SPEED_P001: periods = sar_adc_pkg::CONV_PERIODS_P001;
            sar_adc_pkg::SPEED_P011: periods = sar_adc_pkg::CONV_PERIODS_P011;
            sar_adc_pkg::SPEED_P100: periods = sar_adc_pkg::CONV_PERIODS_P100;
            sar_adc_pkg::SPEED_P101: periods = sar_adc_pkg::CONV_PERIODS_P101;
            default:                 periods = sar_adc_pkg::CONV_PERIODS_P101;
        endcase
        periods = div_sel ? periods : periods * 2;
        return 7'(periods / sar_adc_pkg::SLOTS_PER_CONV);
    endfunction
    // register state
    sar_adc_pkg::mode_s               mode;
    sar_adc_pkg::mode_s               next_mode;
    logic [7:0]                       pin_sel;
    logic [7:0]                       next_pin_sel;
    logic [7:0]                       edge_mode;
    logic [7:0]                       next_edge_mode;
    logic [sar_adc_pkg::DATA_W-1:0]   result;
    logic [sar_adc_pkg::DATA_W-1:0]   next_result;
    logic [31:0]                      rd_dat;
    logic [31:0]                      next_rd_dat;
    logic                             ack;
    logic                             next_ack;
    // conversion state
    sar_adc_pkg::conv_state_e         state;
    sar_adc_pkg::conv_state_e         next_state;
    logic [sar_adc_pkg::DATA_W-1:0]   approximation_reg;
    logic [sar_adc_pkg::DATA_W-1:0]   next_approximation_reg;
    logic [2:0]                       bit_idx;
    logic [2:0]                       next_bit_idx;
    logic [7:0]                       slot_cnt;
    logic [7:0]                       next_slot_cnt;
    logic [PRE_W-1:0]                 pre_cnt;
    logic [PRE_W-1:0]                 next_pre_cnt;
    logic                             done_irq;
    logic                             next_done_irq;
    logic                             sample;
    logic                             next_sample;
    logic [2:0]                       channel_q;
    logic [2:0]                       next_channel_q;
    // pin synchronisers
    logic                             trig_s1;
    logic                             trig_s2;
    logic                             trig_s3;
    logic                             cmp_s1;
    logic                             cmp_s2;
    logic                             fx_tick;
    logic                             trig_edge;
    logic                             mode_wr;
    logic [7:0]                       wr_byte;
    logic [6:0]                       slot;
    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
            cmp_s1  <= 1'b0;
            cmp_s2  <= 1'b0;
        end
        else
        begin
            trig_s1 <= i_conversion_trigger_in;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
            cmp_s1  <= i_comparator;
            cmp_s2  <= cmp_s1;
        end
    end
    always_comb
    begin
        fx_tick = (pre_cnt == PRE_W'(FX_DIV - 1));
        slot    = slot_len(mode, i_clock_divider_select);
        wr_byte = i_wb_dat[7:0];
        mode_wr = i_wb_cyc && i_wb_stb && i_wb_we && ack && i_wb_sel[0] && (i_wb_adr == sar_adc_pkg::MODE_ADDR);
        // trigger edge from bits 1:0 of the edge mode register
        case (edge_mode[1:0])
            sar_adc_pkg::EDGE_FALL: trig_edge = trig_s3 && !trig_s2;
            sar_adc_pkg::EDGE_RISE: trig_edge = !trig_s3 && trig_s2;
            default:                trig_edge = trig_s3 != trig_s2;
        endcase
    end
    // bus side: registers and answers
    always_comb
    begin
        next_ack       = i_wb_cyc && i_wb_stb && !ack;
        next_mode      = mode;
        next_pin_sel   = pin_sel;
        next_edge_mode = edge_mode;
        next_rd_dat    = rd_dat;
        if (i_wb_cyc && i_wb_stb && i_wb_we && ack && i_wb_sel[0])
        begin
            case (i_wb_adr)
                sar_adc_pkg::MODE_ADDR:      next_mode      = sar_adc_pkg::mode_s'(wr_byte);
                sar_adc_pkg::PIN_SEL_ADDR:   next_pin_sel   = wr_byte;
                sar_adc_pkg::EDGE_MODE_ADDR: next_edge_mode = wr_byte;
                default:                     next_mode      = mode;
            endcase
        end
        if (i_wb_cyc && i_wb_stb && !i_wb_we && !ack)
        begin
            case (i_wb_adr)
                sar_adc_pkg::MODE_ADDR:      next_rd_dat = {24'h00_0000, mode};
                sar_adc_pkg::RESULT_ADDR:    next_rd_dat = {24'h00_0000, result};
                sar_adc_pkg::PIN_SEL_ADDR:   next_rd_dat = {24'h00_0000, pin_sel};
                sar_adc_pkg::EDGE_MODE_ADDR: next_rd_dat = {24'h00_0000, edge_mode};
                sar_adc_pkg::STATUS_ADDR:
                begin
                    next_rd_dat = 32'h0000_0000;
                    next_rd_dat[sar_adc_pkg::STAT_BUSY_BIT] = (state == sar_adc_pkg::ST_SAMPLE)
                                                           || (state == sar_adc_pkg::ST_CONVERT);
                    next_rd_dat[sar_adc_pkg::STAT_WAIT_BIT] = (state == sar_adc_pkg::ST_WAIT_TRIG);
                    next_rd_dat[sar_adc_pkg::STAT_IDX_LSB +: 3] = bit_idx;
                end
                default:                     next_rd_dat = 32'h0000_0000;
            endcase
        end
    end
    // conversion sequencer
    always_comb
    begin
        next_state             = state;
        next_approximation_reg = approximation_reg;
        next_bit_idx           = bit_idx;
        next_slot_cnt          = slot_cnt;
        next_pre_cnt           = fx_tick ? '0 : PRE_W'(pre_cnt + 1'b1);
        next_result            = result;
        next_done_irq          = 1'b0;
        next_sample            = 1'b0;
        next_channel_q         = channel_q;
        case (state)
            sar_adc_pkg::ST_IDLE:
            begin
                next_slot_cnt = 8'h00;
            end
            sar_adc_pkg::ST_WAIT_TRIG:
            begin
                next_slot_cnt = 8'h00;
                if (trig_edge)
                begin
                    next_state   = sar_adc_pkg::ST_SAMPLE;
                    next_sample  = 1'b1;
                    next_pre_cnt = '0;
                end
            end
            sar_adc_pkg::ST_SAMPLE:
            begin
                next_sample = 1'b1;
                if (fx_tick)
                begin
                    next_slot_cnt = 8'(slot_cnt + 1'b1);
                    if (slot_cnt == 8'(({1'b0, slot} * 8'(sar_adc_pkg::SAMPLE_SLOTS)) - 8'h01))
                    begin
                        next_sample            = 1'b0;
                        next_state             = sar_adc_pkg::ST_CONVERT;
                        next_slot_cnt          = 8'h00;
                        next_bit_idx           = 3'h7;
                        next_approximation_reg = 8'h80;
                    end
                end
            end
            sar_adc_pkg::ST_CONVERT:
            begin
                if (fx_tick)
                begin
                    next_slot_cnt = 8'(slot_cnt + 1'b1);
                    if (slot_cnt == 8'({1'b0, slot} - 8'h01))
                    begin
                        next_slot_cnt = 8'h00;
                        // keep the trial bit only when input is at or above the tap
                        next_approximation_reg[bit_idx] = cmp_s2;
                        if (bit_idx == 3'h0)
                        begin
                            next_result   = next_approximation_reg;
                            next_done_irq = 1'b1;
                            if (mode.ext_start)
                            begin
                                next_state = sar_adc_pkg::ST_WAIT_TRIG;
                            end
                            else
                            begin
                                next_state  = sar_adc_pkg::ST_SAMPLE;
                                next_sample = 1'b1;
                            end
                        end
                        else
                        begin
                            next_bit_idx = 3'(bit_idx - 1'b1);
                            next_approximation_reg[3'(bit_idx - 1'b1)] = 1'b1;
                        end
                    end
                end
            end
            default:
            begin
                next_state = sar_adc_pkg::ST_IDLE;
            end
        endcase
        // a mode write restarts or halts whatever is in progress
        if (mode_wr)
        begin
            next_slot_cnt          = 8'h00;
            next_pre_cnt           = '0;
            next_done_irq          = 1'b0;
            next_approximation_reg = 8'h00;
            next_channel_q         = wr_byte[sar_adc_pkg::CHANNEL_MSB:sar_adc_pkg::CHANNEL_LSB];
            if (!wr_byte[sar_adc_pkg::RUN_BIT])
            begin
                next_state  = sar_adc_pkg::ST_IDLE;
                next_sample = 1'b0;
            end
            else if (wr_byte[sar_adc_pkg::EXT_START_BIT])
            begin
                next_state  = sar_adc_pkg::ST_WAIT_TRIG;
                next_sample = 1'b0;
            end
            else
            begin
                next_state  = sar_adc_pkg::ST_SAMPLE;
                next_sample = 1'b1;
            end
        end
    end
    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            mode              <= sar_adc_pkg::mode_s'(sar_adc_pkg::MODE_RESET);
            pin_sel           <= sar_adc_pkg::PIN_SEL_RESET;
            edge_mode         <= sar_adc_pkg::EDGE_MODE_RESET;
            rd_dat            <= 32'h0000_0000;
            ack               <= 1'b0;
            state             <= sar_adc_pkg::ST_IDLE;
            approximation_reg <= 8'h00;
            bit_idx           <= 3'h7;
            slot_cnt          <= 8'h00;
            pre_cnt           <= '0;
            done_irq          <= 1'b0;
            sample            <= 1'b0;
            channel_q         <= 3'h0;
            result            <= 8'h00;
        end
        else
        begin
            mode              <= next_mode;
            pin_sel           <= next_pin_sel;
            edge_mode         <= next_edge_mode;
            rd_dat            <= next_rd_dat;
            ack               <= next_ack;
            state             <= next_state;
            approximation_reg <= next_approximation_reg;
            bit_idx           <= next_bit_idx;
            slot_cnt          <= next_slot_cnt;
            pre_cnt           <= next_pre_cnt;
            done_irq          <= next_done_irq;
            sample            <= next_sample;
            channel_q         <= next_channel_q;
            result            <= next_result;
        end
    end
    always_comb
    begin
        o_wb_dat              = rd_dat;
        o_wb_ack              = ack;
        o_channel_sel         = channel_q;
        o_sample              = sample;
        o_tap_code            = approximation_reg;
        o_analog_pin_select   = pin_sel;
        o_conversion_done_irq = done_irq;
    end

endmodule

`default_nettype wire

// ---- bench/sar_adc_control_monitor.sv ----
// checker of the converter control port behaviour
`timescale 1ns/100ps
`default_nettype none
module sar_adc_control_monitor #(
    parameter int FX_DIV = 1
) (
    // clock and reset
    input wire logic        i_core_clk,
    input wire logic        i_nrst,
    // bus
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [15:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0]  i_wb_sel,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    // system and analog side
    input wire logic        i_clock_divider_select,
    input wire logic        i_conversion_trigger_in,
    input wire logic        i_comparator,
    input wire logic [2:0]  o_channel_sel,
    input wire logic        o_sample,
    input wire logic [7:0]  o_tap_code,
    input wire logic [7:0]  o_analog_pin_select,
    input wire logic        o_conversion_done_irq
);
    logic       wr_ok;
    logic       mode_wr;
    logic       pin_wr;
    logic [7:0] mode_q;
    assign wr_ok = o_wb_ack && i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0];
    assign mode_wr = wr_ok && (i_wb_adr == sar_adc_pkg::MODE_ADDR);
    assign pin_wr = wr_ok && (i_wb_adr == sar_adc_pkg::PIN_SEL_ADDR);
    // mode as last written
    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
            mode_q <= sar_adc_pkg::MODE_RESET;
        else if (mode_wr)
            mode_q <= i_wb_dat[7:0];
    end
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);
    sequence halt_seq;
        (!o_sample && o_tap_code == 8'h00) ##1 (!o_conversion_done_irq)[*6];
    endsequence
    irq_pulse_a: assert property (o_conversion_done_irq |=> !o_conversion_done_irq)
        else $error("done pulse too long");
    channel_out_a: assert property (mode_wr |=> o_channel_sel == $past(i_wb_dat[3:1]))
        else $error("channel not driven");
    pin_sel_a: assert property (pin_wr |=> o_analog_pin_select == $past(i_wb_dat[7:0]))
        else $error("pin select not driven");
    stop_halt_a: assert property (mode_wr && !i_wb_dat[7] |=> ##[0:1] halt_seq)
        else $error("stop did not halt");
    sw_start_a: assert property (mode_wr && i_wb_dat[7] && !i_wb_dat[6] |-> ##[1:2] o_sample)
        else $error("software start missing");
    sw_repeat_a: assert property (o_conversion_done_irq && mode_q[7] && !mode_q[6] |-> ##[1:2] o_sample)
        else $error("no repeat conversion");
    hw_once_a: assert property (o_conversion_done_irq && mode_q[6] |=> (!o_sample)[*4])
        else $error("hardware start repeated");
    hw_wait_a: assert property (mode_wr && i_wb_dat[7] && i_wb_dat[6] |=> (!o_sample)[*2])
        else $error("started without trigger");
    msb_first_a: assert property ($fell(o_sample) && mode_q[7] && !$past(mode_wr) |-> ##[0:1] o_tap_code == 8'h80)
        else $error("first trial not msb");
    result_byte_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr == sar_adc_pkg::RESULT_ADDR |-> o_wb_dat[31:8] == 0)
        else $error("result read not a byte");
endmodule
bind sar_adc_control sar_adc_control_monitor #(.FX_DIV(FX_DIV)) mon (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_clock_divider_select(i_clock_divider_select), .i_conversion_trigger_in(i_conversion_trigger_in),
    .i_comparator(i_comparator), .o_channel_sel(o_channel_sel), .o_sample(o_sample), .o_tap_code(o_tap_code),
    .o_analog_pin_select(o_analog_pin_select), .o_conversion_done_irq(o_conversion_done_irq)
);
`default_nettype wire

// ---- bench/analog_front_model.sv ----
// analog multiplexer, sample-hold and comparator model
`timescale 1ns/100ps
`default_nettype none
module analog_front_model (
    // clock
    input wire logic        i_core_clk,
    // one level byte per channel
    input wire logic [63:0] i_levels,
    // converter side
    input wire logic [2:0]  i_channel_sel,
    input wire logic        i_sample,
    input wire logic [7:0]  i_tap_code,
    output var logic        o_comparator
);
    logic [7:0] held = 8'h00;
    initial o_comparator = 1'b0;
    // comparator settles one cycle late
    always @(posedge i_core_clk)
    begin
        if (i_sample)
            held <= i_levels[i_channel_sel*8 +: 8];
        o_comparator <= (held >= i_tap_code);
    end
endmodule
`default_nettype wire

// ---- bench/test_sar_adc_control.sv ----
// self-checking bench of the converter control
`timescale 1ns/100ps
`default_nettype none
module test_sar_adc_control;
    logic        clk;
    logic        nrst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [15:0] adr;
    logic [31:0] wdat;
    logic [3:0]  sel;
    logic [31:0] rdat;
    logic        ack;
    logic        div;
    logic        trig;
    logic        comp;
    logic [2:0]  chan;
    logic        smp;
    logic [7:0]  tap;
    logic [7:0]  pins;
    logic        irq;
    logic [63:0] levels;
    logic [31:0] q;
    logic [7:0]  v;
    int          bad_count = 0;
    int          checked = 0;
    int          irq_n = 0;
    int          n;
    int          cnt;
    logic [2:0]  pats [5] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h0};
    int          hw_exp [3] = '{1, 1, 2};
    sar_adc_control #(.FX_DIV(1)) dut (
        .i_core_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack), .i_clock_divider_select(div),
        .i_conversion_trigger_in(trig), .i_comparator(comp), .o_channel_sel(chan), .o_sample(smp),
        .o_tap_code(tap), .o_analog_pin_select(pins), .o_conversion_done_irq(irq)
    );
    analog_front_model afe (
        .i_core_clk(clk), .i_levels(levels), .i_channel_sel(chan), .i_sample(smp), .i_tap_code(tap),
        .o_comparator(comp)
    );
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
        if (irq === 1'b1)
            irq_n++;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic [15:0] a, input logic w, input logic [7:0] d, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, 24'h0, d, s};
        do
        begin
            @(posedge clk);
            k++;
        end
        while (ack !== 1'b1 && k < 100);
        q = rdat;
        {cyc, stb} <= 2'b00;
        check({31'h0, k < 100}, 32'h1);
    endtask
    task automatic wait_irq();
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (irq !== 1'b1 && n < 1000);
        check({31'h0, n < 1000}, 32'h1);
    endtask
    function automatic logic [7:0] sar_exp(input logic [7:0] lvl);
        logic [7:0] r;
        r = 8'h00;
        for (int b = 7; b >= 0; b--)
        begin
            r[b] = 1'b1;
            if (lvl < r)
                r[b] = 1'b0;
        end
        return r;
    endfunction
    function automatic int conv_len(input logic [2:0] p, input logic d);
        int base;
        case (p)
            3'h1: base = 80;
            3'h3: base = 40;
            3'h4: base = 50;
            default: base = 100;
        endcase
        return d ? base : 2 * base;
    endfunction
    function automatic logic [7:0] mode_byte(input logic run, input logic hw, input logic [2:0] p, input logic [2:0] c);
        return {run, hw, p[2:1], c, p[0]};
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #400000;
        bad_count++;
        close_out();
    end
    initial
    begin
        {nrst, cyc, stb, we, adr, wdat, sel, div, trig} = '0;
        v = 8'($urandom(32'h203b));
        levels = {8'hff, 16'($urandom), 32'($urandom), 8'h00};
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        div <= 1'b1;
        wb(sar_adc_pkg::MODE_ADDR, 1'b0, 8'h00, 4'h1);
        check(q, {24'h0, sar_adc_pkg::MODE_RESET});
        wb(16'hff00, 1'b1, 8'h5a, 4'h1);
        wb(16'hff00, 1'b0, 8'h00, 4'h1);
        check(q, 32'h0);
        wb(sar_adc_pkg::PIN_SEL_ADDR, 1'b0, 8'h00, 4'h1);
        check(q, 32'h0);
        wb(sar_adc_pkg::PIN_SEL_ADDR, 1'b1, v, 4'h1);
        wb(sar_adc_pkg::PIN_SEL_ADDR, 1'b1, ~v, 4'h0);
        wb(sar_adc_pkg::PIN_SEL_ADDR, 1'b0, 8'h00, 4'h1);
        check(q, {24'h0, v});
        for (int c = 0; c < 8; c++)
        begin
            wb(sar_adc_pkg::MODE_ADDR, 1'b1, mode_byte(1'b1, 1'b0, 3'h1, c[2:0]), 4'h1);
            wait_irq();
            wb(sar_adc_pkg::RESULT_ADDR, 1'b0, 8'h00, 4'h1);
            check(q, {24'h0, sar_exp(levels[c*8 +: 8])});
            check({29'h0, chan}, c);
        end
        for (int d = 1; d >= 0; d--)
            for (int i = 0; i < 5; i++)
            begin
                div <= d[0];
                wb(sar_adc_pkg::MODE_ADDR, 1'b1, mode_byte(1'b1, 1'b0, pats[i], 3'h2), 4'h1);
                wait_irq();
                wait_irq();
                check({31'h0, n >= conv_len(pats[i], d[0]) && n <= conv_len(pats[i], d[0]) + 2}, 32'h1);
            end
        div <= 1'b1;
        wb(sar_adc_pkg::MODE_ADDR, 1'b1, mode_byte(1'b1, 1'b0, 3'h1, 3'h0), 4'h1);
        repeat (30) @(posedge clk);
        wb(sar_adc_pkg::MODE_ADDR, 1'b1, mode_byte(1'b1, 1'b0, 3'h1, 3'h5), 4'h1);
        wait_irq();
        check({31'h0, n >= 80}, 32'h1);
        wb(sar_adc_pkg::RESULT_ADDR, 1'b0, 8'h00, 4'h1);
        check(q, {24'h0, sar_exp(levels[47:40])});
        repeat (30) @(posedge clk);
        wb(sar_adc_pkg::MODE_ADDR, 1'b1, mode_byte(1'b0, 1'b0, 3'h1, 3'h5), 4'h1);
        cnt = irq_n;
        repeat (300) @(posedge clk);
        check(irq_n - cnt, 0);
        check({31'h0, smp}, 32'h0);
        for (int e = 0; e < 3; e++)
        begin
            wb(sar_adc_pkg::EDGE_MODE_ADDR, 1'b1, e[7:0], 4'h1);
            wb(sar_adc_pkg::MODE_ADDR, 1'b1, mode_byte(1'b1, 1'b1, 3'h1, 3'h3), 4'h1);
            cnt = irq_n;
            repeat (100) @(posedge clk);
            trig <= 1'b1;
            repeat (200) @(posedge clk);
            trig <= 1'b0;
            repeat (200) @(posedge clk);
            check(irq_n - cnt, hw_exp[e]);
        end
        wb(sar_adc_pkg::STATUS_ADDR, 1'b0, 8'h00, 4'h1);
        check(q, 32'h1 << sar_adc_pkg::STAT_WAIT_BIT);
        wb(sar_adc_pkg::EDGE_MODE_ADDR, 1'b1, {6'h0, sar_adc_pkg::EDGE_RISE}, 4'h1);
        wb(sar_adc_pkg::MODE_ADDR, 1'b1, mode_byte(1'b1, 1'b1, 3'h1, 3'h4), 4'h1);
        cnt = irq_n;
        trig <= 1'b1;
        repeat (30) @(posedge clk);
        wb(sar_adc_pkg::MODE_ADDR, 1'b1, mode_byte(1'b1, 1'b1, 3'h1, 3'h4), 4'h1);
        trig <= 1'b0;
        repeat (300) @(posedge clk);
        check(irq_n - cnt, 0);
        trig <= 1'b1;
        wait_irq();
        wb(sar_adc_pkg::RESULT_ADDR, 1'b0, 8'h00, 4'h1);
        check(q, {24'h0, sar_exp(levels[39:32])});
        close_out();
    end
endmodule
`default_nettype wire
